//--- logic/mbt_pkg.sv
// Package of register map, field layout, reset values and carrier types of the threshold engine.
package mbt_pkg;

  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned Q_W     = 12;
  localparam int unsigned GRAY_W  = 9;
  localparam int unsigned DEPTH   = 512;
  localparam int unsigned PTR_W   = 10;

  // Register offsets.
  localparam logic [7:0] OFF_VERSION_RESET = 8'h0f;
  localparam logic [7:0] OFF_SLOPE_CTRL    = 8'h13;
  localparam logic [7:0] OFF_FLOOR_ENABLES = 8'h14;
  localparam logic [7:0] OFF_TABLE_LOAD    = 8'h15;
  localparam logic [7:0] OFF_STEP_START    = 8'h16;
  localparam logic [7:0] OFF_STEP_END      = 8'h17;
  localparam logic [7:0] OFF_STEP_CTRL     = 8'h18;

  // Field positions.
  localparam int unsigned BIT_SOFT_RESET   = 0;
  localparam int unsigned VER_LSB          = 1;
  localparam int unsigned VER_MSB          = 6;
  localparam int unsigned SLOPE_LSB        = 12;
  localparam int unsigned SLOPE_MSB        = 14;
  localparam int unsigned BIT_MAP_ENABLE   = 15;
  localparam int unsigned BIT_USER_CURVE   = 13;
  localparam int unsigned BIT_DRAW_ENABLE  = 12;
  localparam int unsigned BIT_STEP_ENABLE  = 9;
  localparam int unsigned TRANS_MSB        = 8;

  // Reset values.
  localparam logic [11:0] RST_MAX_Q        = 12'h000;
  localparam logic [2:0]  RST_SLOPE        = 3'h0;
  localparam logic [11:0] RST_MIN_Q        = 12'h000;
  localparam logic [11:0] RST_STEP_START   = 12'h010;
  localparam logic [11:0] RST_STEP_END     = 12'h020;
  localparam logic [8:0]  RST_TRANSITION   = 9'h100;
  localparam logic [5:0]  FW_VERSION       = 6'h01; // Arbitrary value.

  typedef struct packed {
    logic [11:0] maxQ;
    logic [2:0]  slope;
    logic [11:0] minQ;
    logic        drawEnable;
    logic        stepEnable;
    logic [11:0] stepStart;
    logic [11:0] stepEnd;
    logic [8:0]  transition;
  } mbt_curve_cfg_type;

  typedef struct packed {
    logic        valid;
    logic [11:0] q;
  } mbt_thresh_type;

endpackage : mbt_pkg

//--- logic/mbt_curve_drawer.sv
// Drawing engine: sloped and step threshold for one gray level, combinational.
module mbt_curve_drawer (
  // Configuration and query
  input  wire mbt_pkg::mbt_curve_cfg_type cfg,
  input  wire logic [8:0]                 grayLevel,
  // Result
  output logic [11:0]                     drawQ
);

  logic [11:0] decrement;
  logic [12:0] diff;
  logic [11:0] slopeQ;
  logic [11:0] stepQ;

  // 511 times 7 is 3577, so the product always fits twelve bits.
  // Both operands are widened first so the product is formed at twelve bits, not nine.
  assign decrement = 12'(grayLevel) * 12'(cfg.slope);
  assign diff      = {1'b0, cfg.maxQ} - {1'b0, decrement};

  always_comb begin
    if (cfg.minQ > cfg.maxQ) begin
      slopeQ = cfg.minQ;
    end else if (diff[12] || (diff[11:0] < cfg.minQ)) begin
      slopeQ = cfg.minQ;
    end else begin
      slopeQ = diff[11:0];
    end
  end

  // The transition level itself already takes the end value.
  assign stepQ = (grayLevel < cfg.transition) ? cfg.stepStart : cfg.stepEnd;

  always_comb begin
    if (!cfg.drawEnable) begin
      drawQ = 12'h000;
    end else if (cfg.stepEnable) begin
      drawQ = stepQ;
    end else begin
      drawQ = slopeQ;
    end
  end

endmodule : mbt_curve_drawer

//--- logic/mbt_threshold_engine.sv
// Top of the threshold engine: registers, table load port, threshold lookup pipeline.
module mbt_threshold_engine (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // Register port
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  output logic [15:0]      regRdData,
  output logic             regRdValid,
  // Threshold lookup from the contrast mapping
  input  wire logic        grayValid,
  input  wire logic [8:0]  grayLevel,
  output logic             qValid,
  output logic [11:0]      qValue,
  output logic             contrastMapEnable
);

  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] offset);
    regHit = (addr == offset);
  endfunction : regHit

  logic [11:0] maxQ_q;
  logic [2:0]  slope_q;
  logic [11:0] minQ_q;
  logic        mapEnable_q;
  logic        userCurve_q;
  logic        drawEnable_q;
  logic [11:0] stepStart_q;
  logic [11:0] stepEnd_q;
  logic        stepEnable_q;
  logic [8:0]  transition_q;
  logic        softReset_q;
  logic [9:0]  loadPtr_q;
  logic [11:0] table_q [512];
  logic        tableWrite;

  mbt_pkg::mbt_curve_cfg_type cfg;
  logic [11:0]                drawQ;
  logic [11:0]                tableRd_q;
  logic [11:0]                drawQ_q;
  logic                       useTable_q;
  logic                       stage1Valid_q;
  mbt_pkg::mbt_thresh_type    out_q;

  // Soft reset is a one-cycle pulse; the next edge clears the setting registers and the load pointer, but not the table.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      softReset_q <= 1'b0;
    end else begin
      softReset_q <= regWrite && regHit(regAddr, mbt_pkg::OFF_VERSION_RESET)
                     && regWrData[mbt_pkg::BIT_SOFT_RESET] && !softReset_q;
    end
  end

  // Sloped drawing parameters and the source enables.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      maxQ_q       <= mbt_pkg::RST_MAX_Q;
      slope_q      <= mbt_pkg::RST_SLOPE;
      minQ_q       <= mbt_pkg::RST_MIN_Q;
      mapEnable_q  <= 1'b0;
      userCurve_q  <= 1'b0;
      drawEnable_q <= 1'b0;
    end else if (softReset_q) begin
      maxQ_q       <= mbt_pkg::RST_MAX_Q;
      slope_q      <= mbt_pkg::RST_SLOPE;
      minQ_q       <= mbt_pkg::RST_MIN_Q;
      mapEnable_q  <= 1'b0;
      userCurve_q  <= 1'b0;
      drawEnable_q <= 1'b0;
    end else if (regWrite) begin
      if (regHit(regAddr, mbt_pkg::OFF_SLOPE_CTRL)) begin
        maxQ_q  <= regWrData[11:0];
        slope_q <= regWrData[mbt_pkg::SLOPE_MSB:mbt_pkg::SLOPE_LSB];
      end
      if (regHit(regAddr, mbt_pkg::OFF_FLOOR_ENABLES)) begin
        minQ_q       <= regWrData[11:0];
        mapEnable_q  <= regWrData[mbt_pkg::BIT_MAP_ENABLE];
        userCurve_q  <= regWrData[mbt_pkg::BIT_USER_CURVE];
        drawEnable_q <= regWrData[mbt_pkg::BIT_DRAW_ENABLE];
      end
    end
  end

  // Step function parameters.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stepStart_q  <= mbt_pkg::RST_STEP_START;
      stepEnd_q    <= mbt_pkg::RST_STEP_END;
      stepEnable_q <= 1'b0;
      transition_q <= mbt_pkg::RST_TRANSITION;
    end else if (softReset_q) begin
      stepStart_q  <= mbt_pkg::RST_STEP_START;
      stepEnd_q    <= mbt_pkg::RST_STEP_END;
      stepEnable_q <= 1'b0;
      transition_q <= mbt_pkg::RST_TRANSITION;
    end else if (regWrite) begin
      if (regHit(regAddr, mbt_pkg::OFF_STEP_START)) begin
        stepStart_q <= regWrData[11:0];
      end
      if (regHit(regAddr, mbt_pkg::OFF_STEP_END)) begin
        stepEnd_q <= regWrData[11:0];
      end
      if (regHit(regAddr, mbt_pkg::OFF_STEP_CTRL)) begin
        stepEnable_q <= regWrData[mbt_pkg::BIT_STEP_ENABLE];
        transition_q <= regWrData[mbt_pkg::TRANS_MSB:0];
      end
    end
  end

  // Table load pointer; it sticks at 512 so late writes cannot overwrite entry 0.
  assign tableWrite = regWrite && regHit(regAddr, mbt_pkg::OFF_TABLE_LOAD)
                      && !softReset_q && !loadPtr_q[9];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      loadPtr_q <= 10'h000;
    end else if (softReset_q) begin
      loadPtr_q <= 10'h000;
    end else if (tableWrite) begin
      loadPtr_q <= loadPtr_q + 10'h001;
    end
  end

  // The table itself has no reset; contents stay valid only after a full load.
  always_ff @(posedge clock) begin
    if (tableWrite) begin
      table_q[loadPtr_q[8:0]] <= regWrData[11:0];
    end
  end

  // Register reads answer one cycle after the strobe.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        unique case (regAddr)
          mbt_pkg::OFF_VERSION_RESET: regRdData <= {9'h000, mbt_pkg::FW_VERSION, 1'b0};
          mbt_pkg::OFF_SLOPE_CTRL:    regRdData <= {1'b0, slope_q, maxQ_q};
          mbt_pkg::OFF_FLOOR_ENABLES: regRdData <= {mapEnable_q, 1'b0, userCurve_q,
                                                    drawEnable_q, minQ_q};
          mbt_pkg::OFF_STEP_START:    regRdData <= {4'h0, stepStart_q};
          mbt_pkg::OFF_STEP_END:      regRdData <= {4'h0, stepEnd_q};
          mbt_pkg::OFF_STEP_CTRL:     regRdData <= {6'h00, stepEnable_q, transition_q};
          default:                    regRdData <= 16'h0000;
        endcase
      end
    end
  end

  assign cfg = '{maxQ: maxQ_q, slope: slope_q, minQ: minQ_q, drawEnable: drawEnable_q,
                 stepEnable: stepEnable_q, stepStart: stepStart_q, stepEnd: stepEnd_q,
                 transition: transition_q};

  mbt_curve_drawer drawer (
    .cfg       (cfg),
    .grayLevel (grayLevel),
    .drawQ     (drawQ)
  );

  // First lookup stage: table read and drawn value side by side.
  always_ff @(posedge clock) begin
    if (grayValid) begin
      tableRd_q <= table_q[grayLevel];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      drawQ_q       <= 12'h000;
      useTable_q    <= 1'b0;
      stage1Valid_q <= 1'b0;
    end else begin
      stage1Valid_q <= grayValid && !softReset_q;
      if (grayValid) begin
        drawQ_q    <= drawQ;
        useTable_q <= userCurve_q;
      end
    end
  end

  // Second stage: source select; a disabled mapping sees threshold zero, i.e. no effect.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      out_q <= '0;
    end else begin
      out_q.valid <= stage1Valid_q && !softReset_q;
      if (stage1Valid_q) begin
        if (!mapEnable_q) begin
          out_q.q <= 12'h000;
        end else if (useTable_q) begin
          out_q.q <= tableRd_q;
        end else begin
          out_q.q <= drawQ_q;
        end
      end
    end
  end

  assign qValid            = out_q.valid;
  assign qValue            = out_q.q;
  assign contrastMapEnable = mapEnable_q;

endmodule : mbt_threshold_engine

//--- tb/mbt_threshold_engine_asserts.sv
// Checker of register answer and lookup timing of the threshold engine.
module mbt_threshold_engine_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Register port
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic        regRdValid,
  // Threshold lookup
  input wire logic        grayValid,
  input wire logic [8:0]  grayLevel,
  input wire logic        qValid,
  input wire logic [11:0] qValue,
  input wire logic        contrastMapEnable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  // A soft reset drops lookups and writes taken just after it, so those cycles are excluded.
  logic softRst;
  assign softRst = regWrite && regAddr == 8'h0f && regWrData[0];

  property p_read_answer; regRead && !$past(softRst) |=> regRdValid; endproperty
  a_read_answer : assert property (p_read_answer) else $error("read not answered");
  property p_answer_cause; regRdValid |-> $past(regRead); endproperty
  a_answer_cause : assert property (p_answer_cause) else $error("stray read answer");
  property p_version;
    regRdValid && $past(regAddr) == 8'h0f |-> regRdData == {9'h000, mbt_pkg::FW_VERSION, 1'b0};
  endproperty
  a_version : assert property (p_version) else $error("version field wrong");
  property p_lookup;
    grayValid && !softRst && !$past(softRst) ##1 !softRst ##1 !softRst |-> qValid;
  endproperty
  a_lookup : assert property (p_lookup) else $error("lookup not answered");
  property p_q_cause; qValid |-> $past(grayValid, 2); endproperty
  a_q_cause : assert property (p_q_cause) else $error("stray lookup answer");
  property p_map_off;
    qValid && !$past(contrastMapEnable) && !$past(contrastMapEnable, 2) |-> qValue == 12'h000;
  endproperty
  a_map_off : assert property (p_map_off) else $error("threshold while map off");
  property p_map_write;
    regWrite && regAddr == 8'h14 && !$past(softRst) |=> contrastMapEnable == $past(regWrData[15]);
  endproperty
  a_map_write : assert property (p_map_write) else $error("map enable not written");
  property p_map_hold;
    !(regWrite && regAddr == 8'h14) && !softRst && !$past(softRst) |=> $stable(contrastMapEnable);
  endproperty
  a_map_hold : assert property (p_map_hold) else $error("map enable moved");
  property p_soft_clear; softRst |-> ##2 !contrastMapEnable; endproperty
  a_soft_clear : assert property (p_soft_clear) else $error("soft reset kept enable");
endmodule : mbt_threshold_engine_asserts

bind mbt_threshold_engine mbt_threshold_engine_asserts u_asserts (.clock, .nrst, .regWrite,
  .regRead, .regAddr, .regWrData, .regRdData, .regRdValid, .grayValid, .grayLevel, .qValid,
  .qValue, .contrastMapEnable);

//--- tb/mbt_threshold_engine_bench.sv
// Self-checking bench of the threshold engine driven through its register and lookup ports.
module mbt_threshold_engine_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock, nrst, regWrite, regRead, grayValid;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData;
  logic [8:0]  grayLevel;
  logic        regRdValid, qValid, contrastMapEnable;
  logic [11:0] qValue;
  int          err_total, checks;

  localparam logic [15:0] VER_READ = {9'h000, mbt_pkg::FW_VERSION, 1'b0};
  // The unmapped offset 0x30 and the write-only load port both read as zero.
  logic [7:0]  rstAddr [8] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h30, 8'h0f};
  logic [15:0] rstData [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0020, 16'h0100,
                               16'h0000, VER_READ};

  always #25 clock = ~clock;

  mbt_threshold_engine dut (.clock, .nrst, .regWrite, .regRead, .regAddr, .regWrData,
    .regRdData, .regRdValid, .grayValid, .grayLevel, .qValid, .qValue, .contrastMapEnable);

  function automatic logic [11:0] tval(input int i);
    return 12'(i * 7 + 3);
  endfunction : tval

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    cmp({15'h0000, regRdValid}, 16'h0001);
    cmp(regRdData, exp);
  endtask : rd

  // The answer stands for one cycle only, so it is sampled just after its edge.
  task automatic look(input logic [8:0] g, input logic [11:0] exp);
    @(posedge clock);
    grayValid <= 1'b1;
    grayLevel <= g;
    @(posedge clock);
    grayValid <= 1'b0;
    @(posedge clock);
    #1;
    cmp({15'h0000, qValid}, 16'h0001);
    cmp({4'h0, qValue}, {4'h0, exp});
  endtask : look

  initial begin
    repeat (4000) @(posedge clock);
    err_total++;
    $display("unexpected at %0t: run did not finish", $time);
    stop_test;
  end

  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWrData = 16'h0000;
    grayValid = 1'b0;
    grayLevel = 9'h000;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    foreach (rstAddr[i]) rd(rstAddr[i], rstData[i]);
    wr(8'h0f, 16'hfffe);
    rd(8'h0f, VER_READ);
    wr(8'h13, 16'h5100);
    wr(8'h14, 16'h1020);
    look(9'h000, 12'h000);
    wr(8'h14, 16'h9020);
    rd(8'h14, 16'h9020);
    cmp({15'h0000, contrastMapEnable}, 16'h0001);
    look(9'h000, 12'h100);
    look(9'h00a, 12'h0ce);
    look(9'h028, 12'h038);
    look(9'h032, 12'h020);
    look(9'h1ff, 12'h020);
    // Steep slope from the top: the product outgrows nine bits but not the threshold.
    wr(8'h13, 16'h7fff);
    look(9'h100, 12'h8ff);
    look(9'h1ff, 12'h206);
    wr(8'h13, 16'h1010);
    wr(8'h14, 16'h9040);
    look(9'h000, 12'h040);
    look(9'h005, 12'h040);
    wr(8'h16, 16'h0111);
    wr(8'h17, 16'h0222);
    wr(8'h18, 16'h0280);
    rd(8'h18, 16'h0280);
    look(9'h07f, 12'h111);
    look(9'h080, 12'h222);
    look(9'h1ff, 12'h222);
    wr(8'h14, 16'h8040);
    look(9'h000, 12'h000);
    for (int i = 0; i < 513; i++) wr(8'h15, {4'h0, tval(i)});
    wr(8'h14, 16'hb040);
    look(9'h000, tval(0));
    look(9'h001, tval(1));
    look(9'h1ff, tval(511));
    wr(8'h0f, 16'h0001);
    rd(8'h14, 16'h0000);
    rd(8'h18, 16'h0100);
    wr(8'h15, 16'h05a5);
    wr(8'h14, 16'ha000);
    look(9'h000, 12'h5a5);
    look(9'h001, tval(1));
    stop_test;
  end
endmodule : mbt_threshold_engine_bench
